// >>> hssd_shutdown_ctrl.sv
// module: shutdown policy register with apb slave and per-switch fault gating
// ====================================================================
// Notes on behaviour
// [RULE1] a switch with its overvoltage recovery bit set returns to its prior command when overvoltage clears, otherwise it stays off.
// [RULE2] with the overtemperature scope bit 0 any overtemperature stops every switch, with it 1 only the hot switch stops.
// [RULE3] in active mode overvoltage stops each switch unless its own active-mode disable bit is 1.
// [RULE4] in the low-power modes overvoltage stops the switches unless the shared low-power disable bit is 1.
// [RULE5] undervoltage stops the switches unless the undervoltage disable bit is 1.
// [RULE6] with the undervoltage recovery bit set the switches return to prior state after undervoltage, otherwise they stay off.
// [RULE7] bits 4 and 2 to 0 are reserved, read as zero and ignore writes.
// [RULE8] power-on or soft reset clears the whole register to zero.
// [RULE9] a restart reset keeps every configurable bit.
// [RULE10] when a shutdown is disabled the switch keeps following its command while the fault lasts.
//
// Local design decision: the APB slave port.
module hssd_shutdown_ctrl
	import hssd_pkg::*;
#(
	parameter int NSW = HSSD_NSW
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	input wire logic clkEn,
	input wire logic restartReq,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// device state
	input wire hssd_mode_type opMode,
	input wire hssd_fault_type faultIn,
	input wire logic [NSW-1:0] switchCmd,
	// switch drive
	output logic [NSW-1:0] switchOn
);
	// ====================================================================
	// fault pins are asynchronous: two stages before use
	hssd_fault_type faultMeta;
	hssd_fault_type fault;
	logic [15:0] policy;
	logic [NSW-1:0] latchedOff;
	logic [NSW-1:0] switchCmdQ;
	logic softRst;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			faultMeta <= '0;
			fault <= '0;
		end else if (clkEn) begin
			faultMeta <= faultIn;
			fault <= faultMeta;
		end
	end
	// ====================================================================
	// apb decode
	// one compare routine for every register keeps the map decode in one place
	function automatic logic hitAddr(input logic [11:0] addr, input logic [11:0] target);
		return addr == target;
	endfunction : hitAddr
	wire access = psel && penable;
	// read data is captured in the setup cycle so that pready can stay high
	wire readSetup = psel && !penable && !pwrite;
	wire hitPolicy = hitAddr(paddr, HSSD_POLICY_ADDR);
	wire hitCtrl = hitAddr(paddr, HSSD_CTRL_ADDR);
	wire hitStat = hitAddr(paddr, HSSD_STAT_ADDR);
	wire mapped = hitPolicy || hitCtrl || hitStat;
	wire wrPolicy = access && pwrite && hitPolicy && clkEn;
	wire wrSoft = access && pwrite && hitCtrl && clkEn && pwdata[HSSD_CTRL_SOFTRST_BIT];
	// no wait states; limitation: an access made while clkEn is low completes but is dropped
	assign pready = 1'b1;
	assign pslverr = access && !mapped;
	// ====================================================================
	// policy fields
	wire [NSW-1:0] ovRecover = policy[HSSD_OV_REC_LSB +: NSW];
	wire otIndividual = policy[HSSD_OT_SCOPE_BIT];
	wire [NSW-1:0] ovActDis = policy[HSSD_OV_ACT_LSB +: NSW];
	wire ovLpDis = policy[HSSD_OV_LP_BIT];
	wire uvDis = policy[HSSD_UV_SD_BIT];
	wire uvRecover = policy[HSSD_UV_REC_BIT];
	wire lowPower = opMode != HSSD_MODE_ACTIVE;
	// ====================================================================
	// policy register: restart keeps the value, only reset or soft reset clears it
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			policy <= HSSD_POLICY_RESET; // [RULE8]
		end else if (clkEn) begin
			if (softRst) begin
				policy <= HSSD_POLICY_RESET; // [RULE8]
			end else if (wrPolicy) begin
				policy <= pwdata[15:0] & HSSD_POLICY_WMASK; // [RULE7] [RULE9]
			end
		end
	end
	// soft reset takes effect one cycle after the write so the write itself completes
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			softRst <= 1'b0;
		end else if (clkEn) begin
			softRst <= wrSoft;
		end
	end
	// ====================================================================
	// shutdown causes per switch
	wire anyOt = |fault.overtemp;
	wire [NSW-1:0] otStop = otIndividual ? fault.overtemp : {NSW{anyOt}}; // [RULE2]
	wire [NSW-1:0] ovStop = fault.overvolt ? (lowPower ? {NSW{!ovLpDis}} // [RULE4]
		: ~ovActDis) : '0; // [RULE3]
	wire [NSW-1:0] uvStop = {NSW{fault.undervolt && !uvDis}}; // [RULE5]
	wire [NSW-1:0] hold = ovStop | uvStop;
	// a switch stopped by a supply fault without recovery stays off until re-commanded
	wire [NSW-1:0] noRecover = (ovStop & ~ovRecover) | (uvStop & {NSW{!uvRecover}});
	wire [NSW-1:0] cmdRise = switchCmd & ~switchCmdQ;
	wire [NSW-1:0] next_latchedOff = softRst ? '0 : ((latchedOff & ~cmdRise) | noRecover);
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			latchedOff <= '0;
			switchCmdQ <= '0;
			switchOn <= '0;
		end else if (clkEn) begin
			latchedOff <= next_latchedOff; // [RULE1] [RULE6]
			switchCmdQ <= switchCmd;
			switchOn <= switchCmd & ~(hold | otStop | next_latchedOff); // [RULE10]
		end
	end
	// ====================================================================
	// read data
	// ctrl is write-only and unmapped addresses read zero
	wire [31:0] statWord = {{(32-2*NSW){1'b0}}, latchedOff, switchOn};
	wire [31:0] readWord = hitPolicy ? {16'h0000, policy} : hitStat ? statWord : 32'h0000_0000;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prdata <= '0;
		end else if (clkEn && readSetup) begin
			prdata <= readWord;
		end
	end
	// ====================================================================
	// sequences for the checks that span more than one cycle
	sequence s_soft_write;
		clkEn && wrSoft;
	endsequence
	sequence s_soft_apply;
		clkEn && softRst;
	endsequence
	sequence s_read_setup;
		clkEn && readSetup;
	endsequence
	sequence s_cmd_pulse;
		clkEn && !softRst && cmdRise != '0;
	endsequence
	// ====================================================================
	// assertions
	a_reserved_zero: assert property (@(posedge clk) disable iff (!resetn) // [RULE7]
		(policy & ~HSSD_POLICY_WMASK) == '0) else $error("reserved bit set");
	a_write_stores: assert property (@(posedge clk) disable iff (!resetn) // [RULE7]
		wrPolicy && !softRst |=> policy == ($past(pwdata[15:0]) & HSSD_POLICY_WMASK))
		else $error("policy write lost");
	// writes outside the map must leave the policy alone
	a_unmapped_ignored: assert property (@(posedge clk) disable iff (!resetn)
		clkEn && access && pwrite && !mapped && !softRst |=> $stable(policy))
		else $error("unmapped write changed policy");
	a_soft_clears: assert property (@(posedge clk) disable iff (!resetn) // [RULE8]
		softRst && clkEn |=> policy == HSSD_POLICY_RESET) else $error("soft reset kept policy");
	a_soft_arms: assert property (@(posedge clk) disable iff (!resetn) // [RULE8]
		s_soft_write |=> softRst) else $error("soft reset not armed");
	a_soft_path: assert property (@(posedge clk) disable iff (!resetn) // [RULE8]
		s_soft_write ##1 s_soft_apply |=> policy == HSSD_POLICY_RESET && latchedOff == '0)
		else $error("soft reset path incomplete");
	a_restart_keeps: assert property (@(posedge clk) disable iff (!resetn) // [RULE9]
		restartReq && !wrPolicy && !softRst |=> $stable(policy))
		else $error("restart changed policy");
	// read data is judged one cycle after the setup edge that loads it
	a_read_policy: assert property (@(posedge clk) disable iff (!resetn) // [RULE7]
		s_read_setup ##0 hitPolicy |=> prdata == {16'h0000, $past(policy)})
		else $error("policy read wrong");
	a_stat_read: assert property (@(posedge clk) disable iff (!resetn) // [RULE1]
		s_read_setup ##0 hitStat |=> prdata[2*NSW-1:0] == {$past(latchedOff), $past(switchOn)})
		else $error("status read wrong");
	// the freeze check covers every register the bus can see
	a_freeze_holds: assert property (@(posedge clk) disable iff (!resetn)
		!clkEn |=> $stable(policy) && $stable(latchedOff) && $stable(switchOn) && $stable(prdata))
		else $error("state moved while frozen");
	a_ot_all: assert property (@(posedge clk) disable iff (!resetn) // [RULE2]
		clkEn && !otIndividual && anyOt |=> switchOn == '0) else $error("ot did not stop all");
	a_ot_individual: assert property (@(posedge clk) disable iff (!resetn) // [RULE2]
		clkEn && otIndividual |=> (switchOn & $past(fault.overtemp)) == '0)
		else $error("hot switch still on");
	// in individual scope the cool switches must keep running
	a_ot_others_run: assert property (@(posedge clk) disable iff (!resetn) // [RULE2]
		clkEn && !softRst && otIndividual && !fault.overvolt && !fault.undervolt
		&& latchedOff == '0 |=> switchOn == $past(switchCmd & ~fault.overtemp))
		else $error("cool switch stopped");
	a_ov_active: assert property (@(posedge clk) disable iff (!resetn) // [RULE3]
		clkEn && fault.overvolt && !lowPower |=> (switchOn & ~$past(ovActDis)) == '0)
		else $error("ov active not stopped");
	a_ov_lowpower: assert property (@(posedge clk) disable iff (!resetn) // [RULE4]
		clkEn && fault.overvolt && lowPower && !ovLpDis |=> switchOn == '0)
		else $error("ov low power not stopped");
	a_uv_stop: assert property (@(posedge clk) disable iff (!resetn) // [RULE5]
		clkEn && fault.undervolt && !uvDis |=> switchOn == '0) else $error("uv not stopped");
	a_disabled_follows: assert property (@(posedge clk) disable iff (!resetn) // [RULE10]
		clkEn && !softRst && (hold | otStop | next_latchedOff) == '0 |=> switchOn == $past(switchCmd))
		else $error("switch not following command");
	a_ov_disabled_runs: assert property (@(posedge clk) disable iff (!resetn) // [RULE10]
		clkEn && !softRst && fault.overvolt && !lowPower && !fault.undervolt
		&& fault.overtemp == '0 |=> (switchOn & $past(ovActDis & switchCmd & ~latchedOff))
		== $past(ovActDis & switchCmd & ~latchedOff)) else $error("ov disabled switch stopped");
	a_ovlp_disabled_runs: assert property (@(posedge clk) disable iff (!resetn) // [RULE10]
		clkEn && !softRst && fault.overvolt && lowPower && ovLpDis && !fault.undervolt
		&& fault.overtemp == '0 && latchedOff == '0 |=> switchOn == $past(switchCmd))
		else $error("ov low-power disabled switch stopped");
	a_uv_disabled_runs: assert property (@(posedge clk) disable iff (!resetn) // [RULE10]
		clkEn && !softRst && fault.undervolt && uvDis && !fault.overvolt
		&& fault.overtemp == '0 && latchedOff == '0 |=> switchOn == $past(switchCmd))
		else $error("uv disabled switch stopped");
	a_no_recover: assert property (@(posedge clk) disable iff (!resetn) // [RULE1] [RULE6]
		clkEn && !softRst && (noRecover != '0) |=> (latchedOff & $past(noRecover)) == $past(noRecover))
		else $error("no-recover switch not latched");
	a_cmd_release: assert property (@(posedge clk) disable iff (!resetn) // [RULE1]
		s_cmd_pulse |=> (latchedOff & $past(cmdRise & ~noRecover)) == '0)
		else $error("re-command did not release latch");
endmodule : hssd_shutdown_ctrl

// >>> hssd_pkg.sv
// package: register map, field positions and carrier types for the high-side shutdown policy
package hssd_pkg;
	// ====================================================================
	// register map
	localparam int HSSD_NSW = 4;
	localparam logic [7:0] HSSD_POLICY_INDEX = 8'h07;
	localparam logic [11:0] HSSD_POLICY_ADDR = {2'h0, HSSD_POLICY_INDEX, 2'h0};
	localparam logic [11:0] HSSD_CTRL_ADDR = 12'h040;
	localparam logic [11:0] HSSD_STAT_ADDR = 12'h044;
	localparam logic [15:0] HSSD_POLICY_RESET = 16'h0000;
	localparam logic [15:0] HSSD_POLICY_WMASK = 16'hFFE8;
	// ====================================================================
	// field positions
	localparam int HSSD_OV_REC_LSB = 12;
	localparam int HSSD_OT_SCOPE_BIT = 11;
	localparam int HSSD_OV_ACT_LSB = 7;
	localparam int HSSD_OV_LP_BIT = 6;
	localparam int HSSD_UV_SD_BIT = 5;
	localparam int HSSD_UV_REC_BIT = 3;
	localparam int HSSD_CTRL_SOFTRST_BIT = 0;
	// ====================================================================
	// fault inputs and operating mode
	typedef enum logic [1:0] {
		HSSD_MODE_ACTIVE = 2'h0,
		HSSD_MODE_STOP = 2'h1,
		HSSD_MODE_SLEEP = 2'h3
	} hssd_mode_type;
	typedef struct packed {
		logic overvolt;
		logic undervolt;
		logic [HSSD_NSW-1:0] overtemp;
	} hssd_fault_type;
endpackage : hssd_pkg

// >>> tb_top.sv
// testbench: apb access and fault gating checks for the shutdown policy block
module tb_top import hssd_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// ====================================================================
	// stimulus and design
	logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic restartReq = 1'b0, clkEn = 1'b1, pready, pslverr, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] switchCmd = 4'hF, switchOn;
	hssd_mode_type opMode = HSSD_MODE_ACTIVE;
	hssd_fault_type faultIn = '0;
	int errors = 0, tests_run = 0;
	hssd_shutdown_ctrl dut (.clk(clk), .resetn(resetn), .clkEn(clkEn), .restartReq(restartReq),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .opMode(opMode),
		.faultIn(faultIn), .switchCmd(switchCmd), .switchOn(switchOn));
	initial begin
		forever #2 clk = ~clk;
	end
	// ====================================================================
	// shared tasks
	task end_of_test;
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_of_test
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// request held until pready is seen high; the test gives up after 20 cycles
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			errors++;
			end_of_test;
		end
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb
	task rdchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rdchk
	// fault reaches the drive after 3 edges; 5 leaves margin
	task flt(input logic [5:0] f, input hssd_mode_type m, input logic [3:0] e);
		@(posedge clk);
		faultIn <= f;
		opMode <= m;
		repeat (5) @(posedge clk);
		chk({28'h0, switchOn}, {28'h0, e});
	endtask : flt
	// ====================================================================
	// scenarios
	task t_regs;
		rdchk(HSSD_POLICY_ADDR, 32'h0000_0000);
		apb(1'b1, HSSD_POLICY_ADDR, 32'hFFFF_FFFF);
		rdchk(HSSD_POLICY_ADDR, 32'h0000_FFE8);
		apb(1'b1, 12'h100, 32'h0000_0000);
		chk({31'h0, err}, 32'h1);
		@(posedge clk);
		restartReq <= 1'b1;
		repeat (3) @(posedge clk);
		restartReq <= 1'b0;
		rdchk(HSSD_POLICY_ADDR, 32'h0000_FFE8);
		apb(1'b0, 12'h100, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0000_0000);
		rdchk(HSSD_CTRL_ADDR, 32'h0000_0000);
		apb(1'b1, HSSD_CTRL_ADDR, 32'h0000_0001);
		rdchk(HSSD_POLICY_ADDR, 32'h0000_0000);
		$display("test registers done");
	endtask : t_regs
	task t_faults;
		flt(6'h02, HSSD_MODE_ACTIVE, 4'h0);
		flt(6'h00, HSSD_MODE_ACTIVE, 4'hF);
		apb(1'b1, HSSD_POLICY_ADDR, 32'h0000_0880);
		flt(6'h02, HSSD_MODE_ACTIVE, 4'hD);
		flt(6'h20, HSSD_MODE_ACTIVE, 4'h1);
		flt(6'h00, HSSD_MODE_ACTIVE, 4'h1);
		@(posedge clk);
		switchCmd <= 4'h0;
		repeat (3) @(posedge clk);
		switchCmd <= 4'hF;
		apb(1'b1, HSSD_POLICY_ADDR, 32'h0000_F040);
		flt(6'h20, HSSD_MODE_ACTIVE, 4'h0);
		flt(6'h00, HSSD_MODE_ACTIVE, 4'hF);
		flt(6'h20, HSSD_MODE_STOP, 4'hF);
		apb(1'b1, HSSD_POLICY_ADDR, 32'h0000_F020);
		flt(6'h20, HSSD_MODE_SLEEP, 4'h0);
		flt(6'h10, HSSD_MODE_ACTIVE, 4'hF);
		apb(1'b1, HSSD_POLICY_ADDR, 32'h0000_0008);
		flt(6'h10, HSSD_MODE_ACTIVE, 4'h0);
		flt(6'h00, HSSD_MODE_ACTIVE, 4'hF);
		apb(1'b1, HSSD_POLICY_ADDR, 32'h0000_0000);
		flt(6'h10, HSSD_MODE_ACTIVE, 4'h0);
		flt(6'h00, HSSD_MODE_ACTIVE, 4'h0);
		rdchk(HSSD_STAT_ADDR, 32'h0000_00F0);
		$display("test fault gating done");
	endtask : t_faults
	// a re-command pulse while frozen is never seen, so the latch must survive it
	task t_freeze;
		@(posedge clk);
		clkEn <= 1'b0;
		switchCmd <= 4'h0;
		repeat (3) @(posedge clk);
		switchCmd <= 4'hF;
		repeat (3) @(posedge clk);
		clkEn <= 1'b1;
		repeat (3) @(posedge clk);
		chk({28'h0, switchOn}, 32'h0000_0000);
		switchCmd <= 4'h0;
		@(posedge clk);
		switchCmd <= 4'hF;
		repeat (3) @(posedge clk);
		chk({28'h0, switchOn}, 32'h0000_000F);
		apb(1'b1, HSSD_POLICY_ADDR, 32'hFFFF_FFFF);
		@(posedge clk);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		chk({28'h0, switchOn}, 32'h0000_0000);
		resetn <= 1'b1;
		rdchk(HSSD_POLICY_ADDR, 32'h0000_0000);
		$display("test freeze and reset done");
	endtask : t_freeze
	initial begin
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		t_regs;
		t_faults;
		t_freeze;
		end_of_test;
	end
endmodule : tb_top
